// [hdl/mwz_params.svh]
// Constants for the write, calibration and termination block.
// Assumes inclusion by bare name from each design file.
`ifndef MWZ_PARAMS_SVH
`define MWZ_PARAMS_SVH

// Register byte offsets
`define MWZ_OFF_MR0   8'h00
`define MWZ_OFF_MR1   8'h04
`define MWZ_OFF_MR5   8'h08
`define MWZ_OFF_TIM   8'h0C
`define MWZ_OFF_STAT  8'h10

// Register fields
`define MWZ_F_BURST   1:0
`define MWZ_F_NOM     10:8
`define MWZ_B_TERMINATION_STROBE    11
`define MWZ_F_PARK    8:6
`define MWZ_B_DMEN    10
`define MWZ_F_WL      4:0
`define MWZ_F_WR      12:8
`define MWZ_B_CBUSY   0
`define MWZ_B_CDONE   1
`define MWZ_B_SR      2
`define MWZ_B_TERM    3
`define MWZ_B_WBUSY   4
`define MWZ_B_OVL     5
`define MWZ_F_BANKS   11:8
`define MWZ_F_CODE    23:16

// Burst field codes, beat counts and the nominal-off code
`define MWZ_BL_FIX8   2'h0
`define MWZ_BL_OTF    2'h1
`define MWZ_BL_FIX4   2'h2
`define MWZ_BEATS8    4'h8
`define MWZ_BEATS4    4'h4
`define MWZ_NOM_OFF   3'h0

// Command codes on {ras_n, cas_n, we_n}
`define MWZ_CMD_WR    3'h4
`define MWZ_CMD_PRE   3'h2
`define MWZ_CMD_ZQ    3'h6
`define MWZ_CMD_REF   3'h1

// Reset values, counter step and calibration result code
`define MWZ_WL_RST    5'h09
`define MWZ_WR_RST    5'h0C
`define MWZ_CNT_ONE   5'h01
`define MWZ_CODE_RST  8'h00
`define MWZ_CAL_CODE  8'h5A

// Calibration periods in link clock cycles
`define MWZ_ZQINIT_CK 1024
`define MWZ_ZQOPER_CK 512

`endif

// [hdl/mwz_pkg.sv]
// Types shared by the write, calibration and termination block.
// Assumes the constants header is available to the design files.
package mwz_pkg;

    // Link pins as seen from the controller
    typedef struct packed {
        logic       ck;
        logic       cke;
        logic       cs_n;
        logic       act_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic       a10;
        logic       a12;
        logic [1:0] ba;
        logic       termination_control_pin;
        logic       dm_n;
        logic [7:0] dq;
    } mwz_pins_t;

    // Write sequence states
    typedef enum logic [1:0] {
        W_IDLE = 2'b00,
        W_LAT  = 2'b01,
        W_DATA = 2'b10,
        W_REC  = 2'b11
    } mwz_wst_t;

    // One beat toward the array
    typedef struct packed {
        logic       we;
        logic [1:0] bank;
        logic [2:0] beat;
        logic [7:0] data;
    } mwz_core_wr_t;

    // Termination control toward the pads
    typedef struct packed {
        logic       en;
        logic       strobe_en;
        logic [2:0] val;
    } mwz_term_t;

    // Calibration engine state
    typedef struct packed {
        logic        busy;
        logic        first_done;
        logic        done;
        logic [15:0] cnt;
        logic [7:0]  code;
    } mwz_cal_st_t;

    // Main block state
    typedef struct packed {
        mwz_pins_t    s1;
        mwz_pins_t    s2;
        logic         ck_d;
        logic         cke_d;
        logic [1:0]   burst;
        logic [2:0]   nom;
        logic         termination_strobe;
        logic [2:0]   park;
        logic         dm_en;
        logic [4:0]   wl;
        logic [4:0]   wr;
        logic         ap_wr;
        logic [7:0]   ap_addr;
        logic [31:0]  rdata;
        mwz_wst_t     wst;
        logic [4:0]   cnt;
        logic [3:0]   beat;
        logic [3:0]   nbeat;
        logic [3:0]   wbeats;
        logic [1:0]   bank;
        logic         autopre;
        logic         sr;
        logic [3:0]   open;
        logic         ovl;
        mwz_core_wr_t cw;
        logic         pre;
        logic [1:0]   pre_bank;
        logic         ref_p;
        mwz_term_t    term;
    } mwz_st_t;

endpackage

// [hdl/mwz_cal_engine.sv]
// Long calibration engine: counts the allowed period in link clocks.
// Assumes start and tick are one-cycle pulses on hclk.
`timescale 1ns/1ps
`default_nettype none
`include "mwz_params.svh"
module mwz_cal_engine #(
    parameter int INIT_CK = `MWZ_ZQINIT_CK,
    parameter int OPER_CK = `MWZ_ZQOPER_CK
) (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Control
    input  wire logic       start,
    input  wire logic       tick,
    // Result
    output logic            busy,
    output logic            first_done,
    output logic            done,
    output logic [7:0]      code
);
    localparam logic [15:0] INIT_N = INIT_CK[15:0];
    localparam logic [15:0] OPER_N = OPER_CK[15:0];

    // Counter is sixteen bits wide
    generate
        if (INIT_CK < 1 || INIT_CK > 65535 ||
            OPER_CK < 1 || OPER_CK > 65535) begin : g_chk
            $error("calibration period out of range");
        end
    endgenerate

    mwz_pkg::mwz_cal_st_t st;
    mwz_pkg::mwz_cal_st_t n;

    // First run after reset gets the longer period
    always_comb begin
        n = st;
        n.done = 1'b0;
        if (start && !st.busy) begin
            n.busy = 1'b1;
            n.cnt  = st.first_done ? OPER_N : INIT_N;
        end else if (st.busy && tick) begin
            if (st.cnt == 16'h0001) begin
                n.busy       = 1'b0;
                n.done       = 1'b1;
                n.first_done = 1'b1;
                n.code       = `MWZ_CAL_CODE; // Results moved to I/O
            end else begin
                n.cnt = st.cnt - 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    assign busy       = st.busy;
    assign first_done = st.first_done;
    assign done       = st.done;
    assign code       = st.code;
endmodule
`default_nettype wire

// [hdl/mwz_core.sv]
// Device-side write sequencing, calibration start and termination.
// Assumes link pins from another clock and an AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "mwz_params.svh"
module mwz_core #(
    parameter int ZQINIT_CK = `MWZ_ZQINIT_CK,
    parameter int ZQOPER_CK = `MWZ_ZQOPER_CK
) (
    // Clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp,
    // Link pins from the controller
    input  wire mwz_pkg::mwz_pins_t     link_pins,
    // Array side
    output mwz_pkg::mwz_core_wr_t       core_wr,
    output logic                        bank_precharge,
    output logic [1:0]                  precharge_bank,
    output logic                        write_recovery_ref,
    // Pads side
    output mwz_pkg::mwz_term_t          term,
    output logic [7:0]                  io_cal_code,
    output logic                        cal_busy
);
    mwz_pkg::mwz_st_t   st;
    mwz_pkg::mwz_st_t   n;
    mwz_pkg::mwz_pins_t p;
    logic       rise;
    logic       fall;
    logic       cmd_on;
    logic [2:0] code3;
    logic       is_act;
    logic       is_wr;
    logic       is_pre;
    logic       is_zq;
    logic       is_sre;
    logic       is_srx;
    logic       cal_start;
    logic       wr_go;
    logic       odt_ign;
    logic       take;
    logic       cal_first;
    logic       cal_done;

    // Link edges come from the second sync stage only
    assign p      = st.s2;
    assign rise   = p.ck & ~st.ck_d;
    assign fall   = ~p.ck & st.ck_d;
    assign cmd_on = rise & p.cke & ~p.cs_n;
    assign code3  = {p.ras_n, p.cas_n, p.we_n};

    // Command decode on link clock rising edges
    assign is_act = cmd_on & ~p.act_n;
    assign is_wr  = cmd_on & p.act_n & (code3 == `MWZ_CMD_WR);
    assign is_pre = cmd_on & p.act_n & (code3 == `MWZ_CMD_PRE);
    assign is_zq  = cmd_on & p.act_n & (code3 == `MWZ_CMD_ZQ);
    assign is_sre = rise & st.cke_d & ~p.cke & ~p.cs_n & p.act_n &
                    (code3 == `MWZ_CMD_REF) & ~st.sr;
    assign is_srx = rise & st.sr & p.cke;

    // Only the long form starts the engine
    // No wait for the delay line: relock runs alongside
    assign cal_start = is_zq & p.a10 & ~st.sr;

    // A write may preempt recovery unless a close is pending
    assign wr_go = is_wr & ((st.wst == mwz_pkg::W_IDLE) |
                   ((st.wst == mwz_pkg::W_REC) & ~st.autopre));

    // Pin ignored without nominal value or in self-refresh
    assign odt_ign = (st.nom == `MWZ_NOM_OFF) | st.sr;

    // Address phase accepted
    assign take = hsel & hready & htrans[1];

    mwz_cal_engine #(
        .INIT_CK (ZQINIT_CK),
        .OPER_CK (ZQOPER_CK)
    ) u_cal (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .start      (cal_start),
        .tick       (rise),
        .busy       (cal_busy),
        .first_done (cal_first),
        .done       (cal_done),
        .code       (io_cal_code)
    );

    // Next-state logic for the whole block
    always_comb begin
        logic take_beat;
        take_beat = 1'b0;
        n = st;
        n.s1     = link_pins;
        n.s2     = st.s1;
        n.ck_d   = st.s2.ck;
        n.cke_d  = rise ? p.cke : st.cke_d;
        n.cw.we  = 1'b0;
        n.pre    = 1'b0;
        n.ref_p  = 1'b0;
        n.ap_wr  = take & hwrite;
        if (take) begin
            n.ap_addr = haddr[7:0];
        end

        // Register writes in the data phase
        if (st.ap_wr) begin
            case (st.ap_addr)
                `MWZ_OFF_MR0: begin
                    n.burst = hwdata[`MWZ_F_BURST];
                end
                `MWZ_OFF_MR1: begin
                    n.nom  = hwdata[`MWZ_F_NOM];
                    n.termination_strobe = hwdata[`MWZ_B_TERMINATION_STROBE];
                end
                `MWZ_OFF_MR5: begin
                    n.park  = hwdata[`MWZ_F_PARK];
                    n.dm_en = hwdata[`MWZ_B_DMEN];
                end
                `MWZ_OFF_TIM: begin
                    n.wl = hwdata[`MWZ_F_WL];
                    n.wr = hwdata[`MWZ_F_WR];
                end
                `MWZ_OFF_STAT: begin
                    if (hwdata[`MWZ_B_OVL]) begin
                        n.ovl = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Self-refresh entry and exit; exit starts no calibration
        if (is_sre) begin
            n.sr = 1'b1;
        end else if (is_srx) begin
            n.sr = 1'b0;
        end

        // Bank open tracking
        if (is_act) begin
            n.open[p.ba] = 1'b1;
        end
        if (is_pre) begin
            n.open[p.ba] = 1'b0;
        end

        // Write sequence in link clock edges
        case (st.wst)
            mwz_pkg::W_IDLE: begin
            end
            mwz_pkg::W_LAT: begin
                if (rise) begin
                    if (st.cnt == st.wl) begin
                        n.wst     = mwz_pkg::W_DATA;
                        take_beat = 1'b1;
                    end else begin
                        n.cnt = st.cnt + `MWZ_CNT_ONE;
                    end
                end
            end
            mwz_pkg::W_DATA: begin
                if (rise | fall) begin
                    if (st.beat == st.nbeat) begin
                        // Recovery starts at the edge after last beat
                        n.wst   = mwz_pkg::W_REC;
                        n.ref_p = 1'b1;
                        n.cnt   = `MWZ_CNT_ONE;
                    end else begin
                        take_beat = 1'b1;
                    end
                end
            end
            mwz_pkg::W_REC: begin
                if (rise) begin
                    if (st.cnt == st.wr) begin
                        // Close only after recovery elapsed
                        n.wst = mwz_pkg::W_IDLE;
                        if (st.autopre) begin
                            n.open[st.bank] = 1'b0;
                            n.pre           = 1'b1;
                            n.pre_bank      = st.bank;
                        end
                    end else begin
                        n.cnt = st.cnt + `MWZ_CNT_ONE;
                    end
                end
            end
            default: begin
                n.wst = mwz_pkg::W_IDLE;
            end
        endcase

        // One beat per link edge; mask low drops the lane
        if (take_beat) begin
            n.cw.we   = (st.beat < st.wbeats) & (~st.dm_en | p.dm_n);
            n.cw.data = p.dq;
            n.cw.bank = st.bank;
            n.cw.beat = st.beat[2:0];
            n.beat    = st.beat + 4'h1;
        end

        // New write: burst length from the field and chop bit
        if (wr_go) begin
            n.wst     = mwz_pkg::W_LAT;
            n.cnt     = `MWZ_CNT_ONE;
            n.bank    = p.ba;
            n.autopre = p.a10;
            n.beat    = 4'h0;
            case (st.burst)
                `MWZ_BL_FIX4: begin
                    n.nbeat  = `MWZ_BEATS4;
                    n.wbeats = `MWZ_BEATS4;
                end
                `MWZ_BL_OTF: begin
                    n.nbeat  = `MWZ_BEATS8;
                    n.wbeats = p.a12 ? `MWZ_BEATS8 : `MWZ_BEATS4;
                end
                default: begin
                    n.nbeat  = `MWZ_BEATS8;
                    n.wbeats = `MWZ_BEATS8;
                end
            endcase
        end

        // Dropped write flag; a set beats a same-cycle clear
        if (is_wr & ~wr_go) begin
            n.ovl = 1'b1;
        end

        // Parked value only; off in self-refresh and calibration
        n.term.en = ~n.sr & ~cal_busy & (odt_ign | ~p.termination_control_pin);
        n.term.strobe_en = n.term.en & st.termination_strobe;
        n.term.val = st.park;

        // Register fields read from next values, so a write is seen at once
        if (take & ~hwrite) begin
            n.rdata = 32'h0000_0000;
            case (haddr[7:0])
                `MWZ_OFF_MR0: n.rdata[`MWZ_F_BURST] = n.burst;
                `MWZ_OFF_MR1: begin
                    n.rdata[`MWZ_F_NOM]  = n.nom;
                    n.rdata[`MWZ_B_TERMINATION_STROBE] = n.termination_strobe;
                end
                `MWZ_OFF_MR5: begin
                    n.rdata[`MWZ_F_PARK] = n.park;
                    n.rdata[`MWZ_B_DMEN] = n.dm_en;
                end
                `MWZ_OFF_TIM: begin
                    n.rdata[`MWZ_F_WL] = n.wl;
                    n.rdata[`MWZ_F_WR] = n.wr;
                end
                `MWZ_OFF_STAT: begin
                    n.rdata[`MWZ_B_CBUSY] = cal_busy;
                    n.rdata[`MWZ_B_CDONE] = cal_first;
                    n.rdata[`MWZ_B_SR]    = n.sr;
                    n.rdata[`MWZ_B_TERM]  = st.term.en;
                    n.rdata[`MWZ_B_WBUSY] = n.wst != mwz_pkg::W_IDLE;
                    n.rdata[`MWZ_B_OVL]   = n.ovl;
                    n.rdata[`MWZ_F_BANKS] = n.open;
                    n.rdata[`MWZ_F_CODE]  = io_cal_code;
                end
                default: begin
                end
            endcase
        end
    end

    // State register; reset values are constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st       <= '0;
            st.wl    <= `MWZ_WL_RST;
            st.wr    <= `MWZ_WR_RST;
            st.wst   <= mwz_pkg::W_IDLE;
        end else begin
            st <= n;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign hrdata             = st.rdata;
    assign core_wr            = st.cw;
    assign bank_precharge     = st.pre;
    assign precharge_bank     = st.pre_bank;
    assign write_recovery_ref = st.ref_p;
    assign term               = st.term;

    // Checks next to the logic they guard
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_short_cal_ign: assert property (
        is_zq && !p.a10 && !cal_busy |=> !cal_busy
    ) else $error("short calibration started the engine");

    a_long_cal_run: assert property (
        cal_start && !cal_busy |=> cal_busy
    ) else $error("long calibration did not start");

    a_cal_updates_io: assert property (
        $fell(cal_busy) |-> cal_done && io_cal_code == `MWZ_CAL_CODE
    ) else $error("calibration end did not update the code");

    a_no_srx_cal: assert property (
        is_srx && !cal_busy && !cal_start |=> !cal_busy
    ) else $error("calibration started on self-refresh exit");

    a_term_off_sr: assert property (
        st.sr && !is_srx |=> !term.en
    ) else $error("termination on in self-refresh");

    a_term_off_cal: assert property (
        cal_busy |=> !term.en
    ) else $error("termination on during calibration");

    a_odt_ignored: assert property (
        st.nom == `MWZ_NOM_OFF && !st.sr && !is_sre && !cal_busy
        |=> term.en
    ) else $error("control pin not ignored with nominal off");

    a_termination_strobe_term: assert property (
        term.strobe_en == (term.en && $past(st.termination_strobe))
    ) else $error("strobe termination does not follow enable");

    a_dm_blocks: assert property (
        st.wst == mwz_pkg::W_DATA && (rise || fall) && st.dm_en &&
        st.beat != st.nbeat && !p.dm_n |=> !core_wr.we
    ) else $error("masked lane was written");

    a_fix4_len: assert property (
        wr_go && st.burst == `MWZ_BL_FIX4
        |=> st.nbeat == `MWZ_BEATS4 && st.wbeats == `MWZ_BEATS4
    ) else $error("fixed chop burst length wrong");

    a_otf_chop: assert property (
        wr_go && st.burst == `MWZ_BL_OTF && !p.a12
        |=> st.nbeat == `MWZ_BEATS8 && st.wbeats == `MWZ_BEATS4
    ) else $error("on-the-fly chop length wrong");

    a_ref_after_data: assert property (
        write_recovery_ref |-> $past(rise) &&
        $past(st.wst) == mwz_pkg::W_DATA
    ) else $error("recovery reference not at edge after data");

    a_autopre_close: assert property (
        bank_precharge |-> !st.open[precharge_bank] &&
        $past(st.autopre)
    ) else $error("auto precharge did not close the bank");
endmodule
`default_nettype wire

// [bench/mwz_host.sv]
// Host controller model driving commands, beats and levels on the link.
// Assumes one caller at a time; the link clock runs only inside frames.
`timescale 1ns/1ps
`default_nettype none
module mwz_host (
    // Link pins toward the device
    output var mwz_pkg::mwz_pins_t pins
);
    localparam real HP = 62.5;

    // Idle link: deselected, clock low, clock enable high
    initial begin
        pins = '0;
        pins.cke = 1'b1;
        pins.cs_n = 1'b1;
        pins.act_n = 1'b1;
    end

    // Released lines show the inverse of the last value
    function automatic logic [8:0] rel();
        return ~{pins.dm_n, pins.dq};
    endfunction

    // One period from mid-low: f for the fall, n for the next rise
    task automatic cyc(input logic [8:0] f, n);
        #(HP / 2) pins.ck = 1'b1;
        #(HP / 2) {pins.dm_n, pins.dq} = f;
        #(HP / 2) pins.ck = 1'b0;
        #(HP / 2) {pins.dm_n, pins.dq} = n;
    endtask

    // Command taken at the next rise, then deselect
    task automatic cmd(input logic [2:0] c, input logic a10, a12,
                       input logic [1:0] ba, input logic ke);
        {pins.ras_n, pins.cas_n, pins.we_n} = c;
        {pins.a10, pins.a12, pins.ba, pins.cke} = {a10, a12, ba, ke};
        pins.cs_n = 1'b0;
        cyc(rel(), ~rel());
        pins.cs_n = 1'b1;
    endtask

    // Idle periods for recovery and calibration
    task automatic idle(input int k);
        repeat (k) cyc(rel(), ~rel());
    endtask

    // Levels of clock enable and termination pin
    task automatic lvl(input logic ke, od);
        pins.cke = ke;
        pins.termination_control_pin = od;
    endtask

    // Activate opens a bank; act_n is held low for that one command only
    task automatic act(input logic [1:0] ba);
        pins.act_n = 1'b0;
        cmd(3'b111, 1'b0, 1'b0, ba, 1'b1);
        pins.act_n = 1'b1;
    endtask

    // Write command, latency of wl rises, then beats on both edges
    task automatic wr(input logic a10, a12, input logic [1:0] ba,
                      input int wl, k, input logic [8:0] bt [8]);
        cmd(3'b100, a10, a12, ba, 1'b1);
        for (int i = 1; i < wl; i++)
            cyc(rel(), (i == wl - 1) ? bt[0] : ~rel());
        for (int i = 0; i < k; i += 2)
            cyc(bt[i + 1], (i + 2 < k) ? bt[i + 2] : ~bt[i + 1]);
    endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench: registers over AHB-Lite, link traffic from host.
// Assumes the core with calibration periods cut to 8 and 4 link clocks.
`timescale 1ns/1ps
`default_nettype none
`include "mwz_params.svh"
module testbench;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, bank_precharge, write_recovery_ref, cal_busy;
    logic        bsy = 1'b0, dmen = 1'b0, hresp;
    logic [2:0]  hsize = 3'h0;
    logic [1:0]  precharge_bank, bank;
    logic [7:0]  io_cal_code;
    logic [8:0]  bt [8];
    logic [10:0] exp_q [$];
    logic [31:0] seed = 32'h8d95_22e4;
    int          n_mismatch = 0, samples_checked = 0, cyc_n = 0, rises = 0;
    int          r0, exp_ref, cb, np, nb = 0, ncal, wl = 3, wr = 4;
    mwz_pkg::mwz_pins_t    pins;
    mwz_pkg::mwz_core_wr_t core_wr;
    mwz_pkg::mwz_term_t    term;

    mwz_host host (.pins(pins));
    mwz_core #(.ZQINIT_CK(8), .ZQOPER_CK(4)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .link_pins(pins), .core_wr(core_wr),
        .bank_precharge(bank_precharge), .precharge_bank(precharge_bank),
        .write_recovery_ref(write_recovery_ref), .term(term),
        .io_cal_code(io_cal_code), .cal_busy(cal_busy));

    // Clocks: bus clock here, link rises counted for the model
    always #4 hclk = ~hclk;
    always @(posedge pins.ck) rises++;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction

    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Single word transfer; request held until ready is sampled
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        check("hresp", hresp, 1'b0);
    endtask

    // One write burst; the model queues the beats that must land
    task automatic wscen(input logic [1:0] m, input logic a12, a10,
                         input logic [1:0] ba);
        int n;
        n = (m == 2'h2) ? 4 : 8;
        ahb(1'b1, `MWZ_OFF_MR0, {30'h0, m});
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            bt[i] = seed[8:0];
            if (i < ((m == 2'h1 && !a12) ? 4 : n) && !(dmen && !bt[i][8]))
                exp_q.push_back({i[2:0], bt[i][7:0]});
        end
        exp_ref = wl + ((m == 2'h2) ? 2 : 4);
        bank = ba;
        r0 = rises + 1;
        np = 0;
        host.wr(a10, a12, ba, wl, n, bt);
        host.idle(wr + 3);
        check("pre_cnt", np, a10);
        check("left", exp_q.size(), 0);
    endtask

    // Model comparison at every result; also cuts a hang short
    always @(posedge hclk) begin
        if (core_wr.we === 1'b1) begin
            check("beat", {core_wr.beat, core_wr.data},
                  exp_q.size() ? exp_q.pop_front() : 'x);
            check("bank", core_wr.bank, bank);
        end
        if (write_recovery_ref === 1'b1)
            check("ref", rises - r0, exp_ref);
        if (bank_precharge === 1'b1) begin
            np++;
            check("pre", rises - r0, exp_ref + wr);
            check("pre_bank", precharge_bank, bank);
        end
        if (bsy && cal_busy === 1'b1)
            check("term_cal", term.en, 1'b0);
        if (!bsy && cal_busy === 1'b1) begin
            nb++;
            cb = rises;
        end
        if (bsy && cal_busy === 1'b0)
            check("cal_len", rises - cb, ncal);
        bsy = (cal_busy === 1'b1);
        // Ceiling well above the few thousand cycles the run needs
        if (++cyc_n > 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `MWZ_OFF_TIM, 0);
        check("tim_rst", rd, 32'h0000_0c09);
        ahb(1'b1, 32'h0000_0040, 32'hffff_ffff);
        ahb(1'b0, 32'h0000_0040, 0);
        check("unmapped", rd, 32'h0);
        ahb(1'b1, `MWZ_OFF_TIM, 32'h0000_0403);
        host.act(2'h1);
        ahb(1'b0, `MWZ_OFF_STAT, 0);
        check("open", rd[`MWZ_F_BANKS], 4'h2);
        wscen(2'h0, 1'b0, 1'b1, 2'h1);
        ahb(1'b0, `MWZ_OFF_STAT, 0);
        check("closed", rd[`MWZ_F_BANKS], 4'h0);
        wscen(2'h1, 1'b1, 1'b0, 2'h2);
        wscen(2'h1, 1'b0, 1'b1, 2'h3);
        wscen(2'h2, 1'b0, 1'b1, 2'h0);
        ahb(1'b1, `MWZ_OFF_MR5, 32'h0000_0400);
        dmen = 1'b1;
        wscen(2'h3, 1'b1, 1'b0, 2'h1);
        wscen(2'h1, 1'b0, 1'b1, 2'h2);
        for (int p = 0; p < 8; p++) begin
            ahb(1'b1, `MWZ_OFF_MR5, p << 6);
            ahb(1'b0, `MWZ_OFF_MR5, 0);
            check("park", term.val, p);
        end
        host.lvl(1'b1, 1'b1);
        ahb(1'b1, `MWZ_OFF_MR1, 32'h0000_0800);
        ahb(1'b0, `MWZ_OFF_MR1, 0);
        check("strobe", term.strobe_en, 1'b1);
        check("pin_ignored", term.en, 1'b1);
        ahb(1'b1, `MWZ_OFF_MR1, 32'h0000_0200);
        ahb(1'b0, `MWZ_OFF_MR1, 0);
        check("strobe_off", term.strobe_en, 1'b0);
        check("pin_used", term.en, 1'b0);
        host.lvl(1'b1, 1'b0);
        host.cmd(3'b110, 1'b0, 1'b0, 2'h0, 1'b1);
        host.idle(6);
        check("short", nb, 0);
        ncal = 8;
        host.cmd(3'b110, 1'b1, 1'b0, 2'h0, 1'b1);
        host.idle(12);
        ncal = 4;
        host.cmd(3'b110, 1'b1, 1'b0, 2'h0, 1'b1);
        host.idle(8);
        check("cal_cnt", nb, 2);
        check("cal_code", io_cal_code, `MWZ_CAL_CODE);
        host.cmd(3'b001, 1'b0, 1'b0, 2'h0, 1'b0);
        host.idle(3);
        check("term_sr", term.en, 1'b0);
        ahb(1'b0, `MWZ_OFF_STAT, 0);
        check("sr_flag", rd[`MWZ_B_SR], 1'b1);
        host.lvl(1'b1, 1'b0);
        host.idle(8);
        check("no_selfcal", nb, 2);
        check("term_back", term.en, 1'b1);
        host.cmd(3'b110, 1'b1, 1'b0, 2'h0, 1'b1);
        host.idle(8);
        check("cal_after_exit", nb, 3);
        final_report();
    end
endmodule
`default_nettype wire
